// ### bench/nand_identity_param_readout_test.sv
// Bench joining controller and target over the link
`timescale 1ns/1ps
module nand_identity_param_readout_test;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, active, mode, fst, wide;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, stat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] col, col_w;
  logic [15:0] corner [6] = '{16'h0000, 16'h00FF, 16'h0100, 16'(nir_pkg::BASE_END - 1),
    16'(nir_pkg::BASE_END), 16'(nir_pkg::EXT_END - 1)};
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed;
  nir_link_if lnk ();
  nir_host nir_host_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .lnk(lnk));
  nir_dev nir_dev_inst (.aclk(aclk), .aresetn(aresetn), .lnk(lnk), .active(active));
  nir_monitor nir_monitor_inst (.aclk(aclk), .aresetn(aresetn), .cle(lnk.cle), .ale(lnk.ale),
    .we_n(lnk.we_n), .re_n(lnk.re_n), .lclk(lnk.lclk), .sync_mode(lnk.sync_mode), .rdy(lnk.rdy),
    .h_io_out(lnk.h_io_out), .h_io_oe_n(lnk.h_io_oe_n), .d_io_out(lnk.d_io_out),
    .d_io_oe_n(lnk.d_io_oe_n), .io(lnk.io));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task wrap_up();
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the few thousand cycles the sequence needs
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: response %h, expected %h", $time, got, exp);
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    chk_resp(bresp, er);
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Waits on the status word, so only the bench timeout ends a hang
  task run_op(input logic [2:0] op);
    axi_wr(nir_pkg::REG_CTRL, {23'h0, 1'b1, 2'h0, wide, fst, mode, op}, nir_pkg::RESP_OKAY);
    do
      axi_rd(nir_pkg::REG_STAT, stat, resp);
    while (stat[0] !== 1'b0 || stat[1] !== 1'b1);
  endtask
  task op_byte(input logic [2:0] op, input logic [7:0] e);
    run_op(op);
    chk({24'h0, stat[15:8]}, {24'h0, e});
    chk({31'h0, active}, 32'h0);
  endtask
  // Reserved bits are masked to zero whatever the package advertises
  function automatic logic [7:0] desc_exp(input int i);
    case (i)
      0: return nir_pkg::SIG_B0;
      1: return nir_pkg::SIG_B1;
      2: return nir_pkg::SIG_B2;
      3: return nir_pkg::SIG_B3;
      4: return nir_pkg::REV_VAL[7:0] & 8'h0E;
      6: return nir_pkg::FEAT_VAL[7:0];
      8: return nir_pkg::OPT_VAL[7:0];
      9: return nir_pkg::OPT_VAL[15:8] & 8'h01;
      12: return nir_pkg::EXT_LEN_VAL[7:0];
      13: return nir_pkg::EXT_LEN_VAL[15:8];
      14: return nir_pkg::COPIES;
      default: return 8'h00;
    endcase
  endfunction
  initial
  begin
    seed = 92;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, mode, fst, wide} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(nir_pkg::REG_STAT, stat, resp);
    chk({31'h0, stat[2]}, 32'h0);
    axi_wr(8'h0C, 32'h0000_0001, nir_pkg::RESP_SLVERR);
    axi_rd(8'h10, stat, resp);
    chk(stat, 32'h0);
    chk_resp(resp, nir_pkg::RESP_SLVERR);
    for (int p = 0; p < 2; p++)
    begin
      mode = p[0];
      fst = p[0];
      op_byte(nir_pkg::OP_ID_MAKER, nir_pkg::MAKER_CODE);
      op_byte(nir_pkg::OP_READ, nir_pkg::PART_CODE);
      op_byte(nir_pkg::OP_ID_SIG, desc_exp(0));
      for (int i = 1; i < 4; i++)
        op_byte(nir_pkg::OP_READ, desc_exp(i));
      run_op(nir_pkg::OP_DESC);
      chk({31'h0, stat[2]}, 32'h1);
      for (int i = 0; i < 3; i++)
        op_byte(nir_pkg::OP_READ, desc_exp(i));
      op_byte(nir_pkg::OP_STATUS, 8'(1 << nir_pkg::STAT_RDY_BIT));
      run_op(nir_pkg::OP_RESUME);
      for (int i = 3; i < 16; i++)
        op_byte(nir_pkg::OP_READ, desc_exp(i));
    end
    for (int k = 0; k < 14; k++)
    begin
      col = k < 6 ? corner[k] : 16'($unsigned($random(seed)) % nir_pkg::EXT_END);
      mode = 1'($random(seed));
      // Odd passes after the eighth use the wide bus, where the byte column lands on half its value
      wide = k > 8 && k[0];
      col_w = wide ? col >> 1 : col;
      axi_wr(nir_pkg::REG_COL, {16'h0, col}, nir_pkg::RESP_OKAY);
      run_op(nir_pkg::OP_COL);
      op_byte(nir_pkg::OP_READ, col_w < nir_pkg::BASE_END ? desc_exp(int'(col_w) % 256) : 8'h00);
    end
    wrap_up();
  end
endmodule

// ### bench/nir_monitor.sv
// Concurrent checks on the link between controller and target
`timescale 1ns/1ps
module nir_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic lclk,
  input wire logic sync_mode,
  input wire logic rdy,
  input wire logic [7:0] h_io_out,
  input wire logic h_io_oe_n,
  input wire logic [7:0] d_io_out,
  input wire logic d_io_oe_n,
  input wire logic [7:0] io
);
  logic [15:0] busy_cnt_ff;
  logic desc_seen_ff;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Busy length counted here, since a repetition of 100 would be too slow to unroll
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_cnt_ff <= 16'h0000;
      desc_seen_ff <= 1'b0;
    end
    else
    begin
      busy_cnt_ff <= rdy ? 16'h0000 : busy_cnt_ff + 16'h0001;
      if (!rdy)
        desc_seen_ff <= 1'b1;
    end
  end
  property p_one_driver;
    !(!h_io_oe_n && !d_io_oe_n);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive the bus");
  property p_dev_quiet_cmd;
    (cle || ale) |-> d_io_oe_n;
  endproperty
  a_dev_quiet_cmd: assert property (p_dev_quiet_cmd) else $error("target drives during command");
  property p_host_quiet_read;
    (!re_n && !sync_mode) |-> h_io_oe_n;
  endproperty
  a_host_quiet_read: assert property (p_host_quiet_read) else $error("host drives during read");
  property p_latch_driven;
    (!sync_mode && (cle || ale) && $rose(we_n)) |-> $past(!h_io_oe_n);
  endproperty
  a_latch_driven: assert property (p_latch_driven) else $error("latch without host data");
  property p_async_answer;
    (!sync_mode && $fell(re_n)) |-> ##[1:2] !d_io_oe_n;
  endproperty
  a_async_answer: assert property (p_async_answer) else $error("target late on read");
  property p_slow_first;
    (!desc_seen_ff && !sync_mode && $fell(re_n)) |-> !re_n [*5];
  endproperty
  a_slow_first: assert property (p_slow_first) else $error("fast strobe before first descriptor");
  property p_busy_len;
    $rose(rdy) |-> busy_cnt_ff == nir_pkg::DESC_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_sync_edges;
    (sync_mode && !d_io_oe_n && $past(!d_io_oe_n) && $changed(d_io_out))
      |-> ($past(lclk) != $past(lclk, 2)) || ($past(lclk, 2) != $past(lclk, 3));
  endproperty
  a_sync_edges: assert property (p_sync_edges) else $error("sync data moved off an edge");
  c_busy: cover property ($rose(rdy));
  c_sync_read: cover property (sync_mode && !d_io_oe_n && $fell(lclk));
  c_fast_read: cover property (!sync_mode && desc_seen_ff && $fell(re_n));
endmodule

// ### inc/nir_link_if.sv
// Link between the flash controller and the target
`timescale 1ns/1ps
interface nir_link_if;
  logic cle;
  logic ale;
  logic we_n;
  logic re_n;
  logic lclk;
  logic sync_mode;
  logic rdy;
  logic [7:0] h_io_out;
  logic h_io_oe_n;
  logic [7:0] d_io_out;
  logic d_io_oe_n;
  logic [7:0] io;
  // Bus level worked out from the two enables; idle bus floats high
  always_comb
  begin
    if (!h_io_oe_n)
      io = h_io_out;
    else if (!d_io_oe_n)
      io = d_io_out;
    else
      io = 8'hFF;
  end
  modport host (output cle, ale, we_n, re_n, lclk, sync_mode, h_io_out, h_io_oe_n, input rdy, io);
  modport dev (input cle, ale, we_n, re_n, lclk, sync_mode, io, output rdy, d_io_out, d_io_oe_n);
endinterface

// ### inc/nir_pkg.sv
// Shared constants and types for the identify and descriptor readout link
package nir_pkg;
  // Link opcodes and address values
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_DESC = 8'hEC;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESUME = 8'h00;
  localparam logic [7:0] CMD_COL = 8'h05;
  localparam logic [7:0] CMD_COL_GO = 8'hE0;
  localparam logic [7:0] ADDR_MAKER = 8'h00;
  localparam logic [7:0] ADDR_SIG = 8'h20;
  // Identity values, arbitrary
  localparam logic [7:0] SIG_B0 = 8'h51;
  localparam logic [7:0] SIG_B1 = 8'h52;
  localparam logic [7:0] SIG_B2 = 8'h53;
  localparam logic [7:0] SIG_B3 = 8'h54;
  localparam logic [7:0] MAKER_CODE = 8'hA5;
  localparam logic [7:0] PART_CODE = 8'h3C;
  localparam logic [7:0] VENDOR_BYTE = 8'h00;
  // Descriptor field positions and values
  localparam int REV_NEWEST = 3;
  localparam int REV_MIDDLE = 2;
  localparam int REV_OLDEST = 1;
  localparam int FEAT_EXT = 7;
  localparam int FEAT_SYNC = 5;
  localparam logic [15:0] REV_VAL = 16'((1 << REV_NEWEST) | (1 << REV_MIDDLE) | (1 << REV_OLDEST));
  localparam logic [15:0] FEAT_VAL = 16'((1 << FEAT_EXT) | (1 << FEAT_SYNC));
  localparam logic [15:0] OPT_VAL = 16'h0000;
  localparam logic [15:0] EXT_LEN_VAL = 16'h0002;
  localparam logic [7:0] COPIES = 8'h03;
  localparam int PAGE_BYTES = 256;
  localparam int EXT_BYTES = 32;
  localparam int BASE_END = PAGE_BYTES * 3;
  localparam int EXT_END = BASE_END + EXT_BYTES * 3;
  localparam int STAT_RDY_BIT = 6;
  // Timing
  localparam int CLK_NS = 10;
  localparam int T_DESC_NS = 1000;
  localparam logic [15:0] DESC_CYC = 16'(T_DESC_NS / CLK_NS);
  localparam logic [3:0] DIV_SLOW = 4'h5;
  localparam logic [3:0] DIV_FAST = 4'h2;
  // Controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    OP_ID_MAKER = 3'b000, OP_ID_SIG = 3'b001, OP_DESC = 3'b010, OP_COL = 3'b011,
    OP_READ = 3'b100, OP_STATUS = 3'b101, OP_RESUME = 3'b110
  } nir_op_e;
  typedef enum logic [1:0] {SRC_MAKER = 2'b00, SRC_SIG = 2'b01, SRC_PAGE = 2'b10} nir_src_e;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ADDR = 3'b001, D_BUSY = 3'b010, D_OUT = 3'b011, D_COLA = 3'b100, D_COLW = 3'b101
  } nir_dst_e;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_CMD = 3'b001, H_ADR = 3'b010, H_ADR2 = 3'b011, H_CMD2 = 3'b100,
    H_WAIT = 3'b101, H_RD = 3'b110
  } nir_hst_e;
endpackage

// ### rtl/nir_desc_rom.sv
// Constant descriptor content, basic copy only; extended reads return zero
`timescale 1ns/1ps
module nir_desc_rom (
  input wire logic ext_sel,
  input wire logic [7:0] idx,
  output logic [7:0] data
);
  // Fixed table, never written, so it stays valid across power events
  always_comb
  begin
    data = 8'h00;
    if (!ext_sel)
    begin
      case (idx)
        8'h00: data = nir_pkg::SIG_B0;
        8'h01: data = nir_pkg::SIG_B1;
        8'h02: data = nir_pkg::SIG_B2;
        8'h03: data = nir_pkg::SIG_B3;
        8'h04: data = nir_pkg::REV_VAL[7:0];
        8'h05: data = nir_pkg::REV_VAL[15:8];
        8'h06: data = nir_pkg::FEAT_VAL[7:0];
        8'h07: data = nir_pkg::FEAT_VAL[15:8];
        8'h08: data = nir_pkg::OPT_VAL[7:0];
        8'h09: data = nir_pkg::OPT_VAL[15:8];
        8'h0C: data = nir_pkg::EXT_LEN_VAL[7:0];
        8'h0D: data = nir_pkg::EXT_LEN_VAL[15:8];
        8'h0E: data = nir_pkg::COPIES;
        default: data = 8'h00;
      endcase
    end
  end
endmodule

// ### rtl/nir_dev.sv
// Target end: identify and descriptor readout over the link
`timescale 1ns/1ps
module nir_dev (
  input wire logic aclk,
  input wire logic aresetn,
  nir_link_if.dev lnk,
  output logic active
);
  typedef struct packed {
    nir_pkg::nir_dst_e st;
    nir_pkg::nir_src_e src;
    logic [7:0] cmd;
    logic acnt;
    logic stat;
    logic [15:0] ptr;
    logic [15:0] col;
    logic [15:0] bcnt;
    logic we_q;
    logic re_q;
    logic lclk_q;
    logic [7:0] dout;
    logic oe_n;
  } nir_dev_s;

  nir_dev_s cur_ff;
  nir_dev_s nxt_cur;
  logic rom_ext;
  logic [7:0] rom_idx;
  logic [7:0] rom_data;
  logic in_ext;
  logic [15:0] ext_off;
  logic latch;
  logic adv;
  logic refresh;
  logic [7:0] out_byte;
  logic [7:0] stat_byte;

  // Extended window lies after all basic copies
  assign ext_off = cur_ff.ptr - 16'(nir_pkg::BASE_END);
  assign in_ext = (cur_ff.src == nir_pkg::SRC_PAGE) && (cur_ff.ptr >= 16'(nir_pkg::BASE_END));
  assign rom_ext = in_ext;
  assign rom_idx = in_ext ? 8'(ext_off % nir_pkg::EXT_BYTES) : cur_ff.ptr[7:0];

  nir_desc_rom u_rom (
    .ext_sel(rom_ext),
    .idx(rom_idx),
    .data(rom_data)
  );

  assign active = !cur_ff.oe_n;
  assign lnk.d_io_out = cur_ff.dout;
  assign lnk.d_io_oe_n = cur_ff.oe_n;
  assign lnk.rdy = (cur_ff.st != nir_pkg::D_BUSY);

  always_comb
  begin
    // Strobe edges of both modes; inputs are taken as synchronous
    if (lnk.sync_mode)
    begin
      latch = lnk.lclk && !cur_ff.lclk_q && (lnk.cle || lnk.ale);
      adv = !lnk.lclk && cur_ff.lclk_q && !cur_ff.re_q;
      refresh = (lnk.lclk != cur_ff.lclk_q);
    end
    else
    begin
      latch = lnk.we_n && !cur_ff.we_q && (lnk.cle || lnk.ale);
      adv = lnk.re_n && !cur_ff.re_q;
      refresh = 1'b1;
    end
  end

  always_comb
  begin
    stat_byte = 8'h00;
    stat_byte[nir_pkg::STAT_RDY_BIT] = (cur_ff.st != nir_pkg::D_BUSY);
    out_byte = 8'h00;
    case (cur_ff.src)
      nir_pkg::SRC_MAKER:
      begin
        if (cur_ff.ptr == 16'h0000)
          out_byte = nir_pkg::MAKER_CODE;
        else if (cur_ff.ptr == 16'h0001)
          out_byte = nir_pkg::PART_CODE;
        else
          out_byte = nir_pkg::VENDOR_BYTE;
      end
      nir_pkg::SRC_SIG:
      begin
        if (cur_ff.ptr < 16'h0004)
          out_byte = rom_data;
        else
          out_byte = 8'h00;
      end
      nir_pkg::SRC_PAGE:
      begin
        if (cur_ff.ptr < 16'(nir_pkg::BASE_END))
          out_byte = rom_data;
        else if (nir_pkg::FEAT_VAL[nir_pkg::FEAT_EXT] && cur_ff.ptr < 16'(nir_pkg::EXT_END))
          out_byte = rom_data;
        else
          out_byte = 8'h00;
      end
      default: out_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.we_q = lnk.we_n;
    nxt_cur.re_q = lnk.re_n;
    nxt_cur.lclk_q = lnk.lclk;
    if (latch && lnk.cle)
    begin
      case (lnk.io)
        nir_pkg::CMD_IDENT:
        begin
          nxt_cur.cmd = lnk.io;
          nxt_cur.st = nir_pkg::D_ADDR;
          nxt_cur.stat = 1'b0;
        end
        nir_pkg::CMD_DESC:
        begin
          nxt_cur.cmd = lnk.io;
          nxt_cur.st = nir_pkg::D_ADDR;
          nxt_cur.stat = 1'b0;
        end
        nir_pkg::CMD_STATUS: nxt_cur.stat = 1'b1;
        nir_pkg::CMD_RESUME: nxt_cur.stat = 1'b0;
        nir_pkg::CMD_COL:
        begin
          if (cur_ff.st != nir_pkg::D_BUSY)
          begin
            nxt_cur.st = nir_pkg::D_COLA;
            nxt_cur.acnt = 1'b0;
            nxt_cur.stat = 1'b0;
          end
        end
        nir_pkg::CMD_COL_GO:
        begin
          if (cur_ff.st == nir_pkg::D_COLW)
          begin
            nxt_cur.ptr = cur_ff.col;
            nxt_cur.st = nir_pkg::D_OUT;
          end
        end
        default: nxt_cur.stat = cur_ff.stat;
      endcase
    end
    else if (latch && lnk.ale)
    begin
      case (cur_ff.st)
        nir_pkg::D_ADDR:
        begin
          nxt_cur.ptr = 16'h0000;
          if (cur_ff.cmd == nir_pkg::CMD_DESC)
          begin
            nxt_cur.src = nir_pkg::SRC_PAGE;
            nxt_cur.st = nir_pkg::D_BUSY;
            nxt_cur.bcnt = nir_pkg::DESC_CYC;
          end
          else
          begin
            // Any address but the signature one falls back to codes
            nxt_cur.src = (lnk.io == nir_pkg::ADDR_SIG) ? nir_pkg::SRC_SIG : nir_pkg::SRC_MAKER;
            nxt_cur.st = nir_pkg::D_OUT;
          end
        end
        nir_pkg::D_COLA:
        begin
          if (!cur_ff.acnt)
          begin
            nxt_cur.col[7:0] = lnk.io;
            nxt_cur.acnt = 1'b1;
          end
          else
          begin
            nxt_cur.col[15:8] = lnk.io;
            nxt_cur.st = nir_pkg::D_COLW;
          end
        end
        default: nxt_cur.st = cur_ff.st;
      endcase
    end
    else if (cur_ff.st == nir_pkg::D_BUSY)
    begin
      if (cur_ff.bcnt <= 16'h0001)
        nxt_cur.st = nir_pkg::D_OUT;
      else
        nxt_cur.bcnt = cur_ff.bcnt - 16'h0001;
    end
    else if (adv && cur_ff.st == nir_pkg::D_OUT && !cur_ff.stat && cur_ff.ptr != 16'hFFFF)
    begin
      nxt_cur.ptr = cur_ff.ptr + 16'h0001;
    end
    // Drive only while the host holds its read strobe low
    nxt_cur.oe_n = !(!lnk.re_n && (cur_ff.stat || cur_ff.st == nir_pkg::D_OUT));
    if (refresh)
      nxt_cur.dout = cur_ff.stat ? stat_byte : out_byte;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_ff <= '0;
      cur_ff.st <= nir_pkg::D_IDLE;
      cur_ff.we_q <= 1'b1;
      cur_ff.re_q <= 1'b1;
      cur_ff.oe_n <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end
endmodule

// ### rtl/nir_host.sv
// Controller end: AXI4-Lite orders turned into link cycles
`timescale 1ns/1ps
module nir_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  nir_link_if.host lnk
);
  typedef struct packed {
    nir_pkg::nir_hst_e st;
    nir_pkg::nir_op_e op;
    logic sync;
    logic fast;
    logic bus16;
    logic [15:0] col;
    logic busy;
    logic done;
    logic seen;
    logic [7:0] rbyte;
    logic [3:0] div_cnt;
    logic ph;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic lclk;
    logic [7:0] io_out;
    logic io_oe_n;
    logic aw_got;
    logic [7:0] aw_q;
    logic w_got;
    logic [31:0] w_q;
    logic [3:0] s_q;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } nir_host_s;

  nir_host_s cur_ff;
  nir_host_s nxt_cur;
  logic tick;
  logic [15:0] col_link;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == nir_pkg::REG_CTRL) || (a == nir_pkg::REG_COL) || (a == nir_pkg::REG_STAT);
  endfunction

  assign awready = !cur_ff.aw_got && !cur_ff.bvalid;
  assign wready = !cur_ff.w_got && !cur_ff.bvalid;
  assign arready = !cur_ff.rvalid;
  assign bvalid = cur_ff.bvalid;
  assign bresp = cur_ff.bresp;
  assign rvalid = cur_ff.rvalid;
  assign rresp = cur_ff.rresp;
  assign rdata = cur_ff.rdata;
  assign lnk.cle = cur_ff.cle;
  assign lnk.ale = cur_ff.ale;
  assign lnk.we_n = cur_ff.we_n;
  assign lnk.re_n = cur_ff.re_n;
  assign lnk.lclk = cur_ff.lclk;
  assign lnk.sync_mode = cur_ff.sync;
  assign lnk.h_io_out = cur_ff.io_out;
  assign lnk.h_io_oe_n = cur_ff.io_oe_n;
  assign tick = (cur_ff.div_cnt == 4'h0);
  // Column kept in bytes by software, sent in words on a wide bus
  assign col_link = cur_ff.bus16 ? {1'b0, cur_ff.col[15:1]} : cur_ff.col;

  always_comb
  begin
    nxt_cur = cur_ff;
    // Slowest phase length until the first descriptor read has completed
    if (tick)
      nxt_cur.div_cnt = (cur_ff.fast && cur_ff.seen) ? nir_pkg::DIV_FAST - 4'h1 : nir_pkg::DIV_SLOW - 4'h1;
    else
      nxt_cur.div_cnt = cur_ff.div_cnt - 4'h1;
    if (awvalid && awready)
    begin
      nxt_cur.aw_got = 1'b1;
      nxt_cur.aw_q = awaddr;
    end
    if (wvalid && wready)
    begin
      nxt_cur.w_got = 1'b1;
      nxt_cur.w_q = wdata;
      nxt_cur.s_q = wstrb;
    end
    if (cur_ff.aw_got && cur_ff.w_got)
    begin
      nxt_cur.aw_got = 1'b0;
      nxt_cur.w_got = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = mapped(cur_ff.aw_q) ? nir_pkg::RESP_OKAY : nir_pkg::RESP_SLVERR;
      if (cur_ff.aw_q == nir_pkg::REG_CTRL && cur_ff.s_q[0] && !cur_ff.busy)
      begin
        nxt_cur.op = nir_pkg::nir_op_e'(cur_ff.w_q[2:0]);
        nxt_cur.sync = cur_ff.w_q[3];
        nxt_cur.fast = cur_ff.w_q[4];
        nxt_cur.bus16 = cur_ff.w_q[5];
      end
      if (cur_ff.aw_q == nir_pkg::REG_CTRL && cur_ff.s_q[1] && cur_ff.w_q[8] && !cur_ff.busy)
      begin
        nxt_cur.busy = 1'b1;
        nxt_cur.done = 1'b0;
        nxt_cur.ph = 1'b0;
        // Restart the divider so the first strobe phase is full length and io has settled when sampled
        nxt_cur.div_cnt = (cur_ff.w_q[4] && cur_ff.seen) ? nir_pkg::DIV_FAST - 4'h1 : nir_pkg::DIV_SLOW - 4'h1;
        nxt_cur.st = (cur_ff.w_q[2:0] == nir_pkg::OP_READ) ? nir_pkg::H_RD : nir_pkg::H_CMD;
      end
      if (cur_ff.aw_q == nir_pkg::REG_COL && cur_ff.s_q[0])
        nxt_cur.col[7:0] = cur_ff.w_q[7:0];
      if (cur_ff.aw_q == nir_pkg::REG_COL && cur_ff.s_q[1])
        nxt_cur.col[15:8] = cur_ff.w_q[15:8];
    end
    if (cur_ff.bvalid && bready)
      nxt_cur.bvalid = 1'b0;
    if (arvalid && arready)
    begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp = mapped(araddr) ? nir_pkg::RESP_OKAY : nir_pkg::RESP_SLVERR;
      nxt_cur.rdata = 32'h00000000;
      if (araddr == nir_pkg::REG_CTRL)
        nxt_cur.rdata = {26'h0, cur_ff.bus16, cur_ff.fast, cur_ff.sync, cur_ff.op};
      else if (araddr == nir_pkg::REG_COL)
        nxt_cur.rdata = {16'h0, cur_ff.col};
      else if (araddr == nir_pkg::REG_STAT)
        nxt_cur.rdata = {16'h0, cur_ff.rbyte, 5'h0, cur_ff.seen, cur_ff.done, cur_ff.busy};
    end
    else if (cur_ff.rvalid && rready)
      nxt_cur.rvalid = 1'b0;
    // Link sequencer: each cycle is a strobe-low and a strobe-high phase
    if (cur_ff.st == nir_pkg::H_WAIT)
    begin
      if (lnk.rdy)
      begin
        nxt_cur.st = nir_pkg::H_IDLE;
        nxt_cur.busy = 1'b0;
        nxt_cur.done = 1'b1;
        nxt_cur.seen = 1'b1;
      end
    end
    else if (cur_ff.st != nir_pkg::H_IDLE && tick)
    begin
      nxt_cur.ph = !cur_ff.ph;
      // One copy per byte: async at strobe low, sync at the falling clock edge only
      if (cur_ff.st == nir_pkg::H_RD && (cur_ff.sync == cur_ff.ph))
        nxt_cur.rbyte = lnk.io;
      if (cur_ff.ph)
      begin
        case (cur_ff.st)
          nir_pkg::H_CMD:
          begin
            if (cur_ff.op == nir_pkg::OP_STATUS)
              nxt_cur.st = nir_pkg::H_RD;
            else if (cur_ff.op == nir_pkg::OP_RESUME)
              nxt_cur.st = nir_pkg::H_IDLE;
            else
              nxt_cur.st = nir_pkg::H_ADR;
          end
          nir_pkg::H_ADR:
          begin
            if (cur_ff.op == nir_pkg::OP_DESC)
              nxt_cur.st = nir_pkg::H_WAIT;
            else if (cur_ff.op == nir_pkg::OP_COL)
              nxt_cur.st = nir_pkg::H_ADR2;
            else
              nxt_cur.st = nir_pkg::H_RD;
          end
          nir_pkg::H_ADR2: nxt_cur.st = nir_pkg::H_CMD2;
          default: nxt_cur.st = nir_pkg::H_IDLE;
        endcase
        if (nxt_cur.st == nir_pkg::H_IDLE)
        begin
          nxt_cur.busy = 1'b0;
          nxt_cur.done = 1'b1;
        end
      end
    end
    // Pins follow the next state so that they leave flip-flops
    nxt_cur.cle = (nxt_cur.st == nir_pkg::H_CMD) || (nxt_cur.st == nir_pkg::H_CMD2);
    nxt_cur.ale = (nxt_cur.st == nir_pkg::H_ADR) || (nxt_cur.st == nir_pkg::H_ADR2);
    nxt_cur.io_oe_n = !(nxt_cur.cle || nxt_cur.ale);
    nxt_cur.we_n = !((nxt_cur.cle || nxt_cur.ale) && !nxt_cur.sync && !nxt_cur.ph);
    nxt_cur.re_n = !(nxt_cur.st == nir_pkg::H_RD && (nxt_cur.sync || !nxt_cur.ph));
    nxt_cur.lclk = nxt_cur.sync && nxt_cur.ph && (nxt_cur.st != nir_pkg::H_IDLE);
    case (nxt_cur.st)
      nir_pkg::H_CMD:
      begin
        case (cur_ff.op)
          nir_pkg::OP_DESC: nxt_cur.io_out = nir_pkg::CMD_DESC;
          nir_pkg::OP_COL: nxt_cur.io_out = nir_pkg::CMD_COL;
          nir_pkg::OP_STATUS: nxt_cur.io_out = nir_pkg::CMD_STATUS;
          nir_pkg::OP_RESUME: nxt_cur.io_out = nir_pkg::CMD_RESUME;
          default: nxt_cur.io_out = nir_pkg::CMD_IDENT;
        endcase
      end
      nir_pkg::H_ADR:
      begin
        if (cur_ff.op == nir_pkg::OP_COL)
          nxt_cur.io_out = col_link[7:0];
        else if (cur_ff.op == nir_pkg::OP_ID_SIG)
          nxt_cur.io_out = nir_pkg::ADDR_SIG;
        else
          nxt_cur.io_out = nir_pkg::ADDR_MAKER;
      end
      nir_pkg::H_ADR2: nxt_cur.io_out = col_link[15:8];
      nir_pkg::H_CMD2: nxt_cur.io_out = nir_pkg::CMD_COL_GO;
      default: nxt_cur.io_out = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_ff <= '0;
      cur_ff.st <= nir_pkg::H_IDLE;
      cur_ff.op <= nir_pkg::OP_ID_MAKER;
      cur_ff.we_n <= 1'b1;
      cur_ff.re_n <= 1'b1;
      cur_ff.io_oe_n <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end
endmodule
